//--- verilog/mis_cfg.svh
// Constants for the instruction subset executor: offsets, fields, opcodes
`ifndef MIS_CFG_SVH
`define MIS_CFG_SVH

// Register byte offsets on the Avalon slave
`define MIS_OFF_CTRL      8'h00
`define MIS_OFF_ACC       8'h04
`define MIS_OFF_STATUS    8'h08
`define MIS_OFF_BANK_SEL  8'h0C
`define MIS_OFF_PROD_LO   8'h10
`define MIS_OFF_PROD_HI   8'h14
`define MIS_OFF_PC        8'h18
`define MIS_OFF_STK_TOP   8'h1C
`define MIS_OFF_STK_PTR   8'h20
`define MIS_OFF_IRQ_EN    8'h24
`define MIS_OFF_SHADOW    8'h28
`define MIS_OFF_PC_LATCH  8'h2C
`define MIS_OFF_DM_ADDR   8'h30
`define MIS_OFF_DM_DATA   8'h34

// Status flag positions
`define MIS_ST_C   0
`define MIS_ST_HC  1
`define MIS_ST_Z   2
`define MIS_ST_SW  3
`define MIS_ST_N   4

// Opcode patterns
`define MIS_OPC_POP      16'h0006
`define MIS_OPC_PUSH     16'h0005
`define MIS_OPC_RESET    16'h00FF
`define MIS_OPC_IRET     15'h0008
`define MIS_OPC_RET_LIT  8'h0C
`define MIS_OPC_MUL_LIT  8'h0D
`define MIS_OPC_MUL_REG  7'h01
`define MIS_OPC_NEGATE   7'h36
`define MIS_OPC_REL_CALL 5'h1B
`define MIS_OPC_FILLER   4'hF

// Access bank halves and program counter step
`define MIS_ACC_LO_BANK  4'h0
`define MIS_ACC_HI_BANK  4'hF
`define MIS_PC_STEP      2

`endif

//--- verilog/mis_pkg.sv
// Types shared by the instruction subset executor
package mis_pkg;

  // Quarter phases of the first cycle, then idle quarters of a second cycle
  typedef enum logic [3:0] {
    PH_IDLE = 4'h0,
    PH_Q1   = 4'h1,
    PH_Q2   = 4'h2,
    PH_Q3   = 4'h3,
    PH_Q4   = 4'h4,
    PH_N1   = 4'h5,
    PH_N2   = 4'h6,
    PH_N3   = 4'h7,
    PH_N4   = 4'h8
  } mis_phase_t;

  // Decoded operations
  typedef enum logic [3:0] {
    OP_NOP      = 4'h0,
    OP_NEGATE   = 4'h1,
    OP_MUL_REG  = 4'h2,
    OP_MUL_LIT  = 4'h3,
    OP_POP      = 4'h4,
    OP_PUSH     = 4'h5,
    OP_REL_CALL = 4'h6,
    OP_RESET    = 4'h7,
    OP_IRET     = 4'h8,
    OP_RET_LIT  = 4'h9
  } mis_op_t;

endpackage : mis_pkg

//--- verilog/mis_alu_if.sv
// Carrier between the sequencer and the arithmetic unit
`timescale 1ns/10ps
`default_nettype none

interface mis_alu_if;
  logic [7:0]  acc;        // Accumulator operand
  logic [7:0]  opnd;       // Data byte operand
  logic [7:0]  lit;        // Literal operand
  logic        use_lit;    // Multiply by literal instead of data byte
  logic [7:0]  neg_res;    // Negated data byte
  logic [4:0]  neg_flags;  // Flags of the negation
  logic [15:0] prod;       // Unsigned product

  modport alu  (input acc, opnd, lit, use_lit, output neg_res, neg_flags, prod);
  modport core (output acc, opnd, lit, use_lit, input neg_res, neg_flags, prod);
endinterface : mis_alu_if

`default_nettype wire

//--- verilog/mis_alu.sv
// Arithmetic unit: negate with flags and 8 x 8 multiply
`timescale 1ns/10ps
`default_nettype none
`include "mis_cfg.svh"

module mis_alu (
  mis_alu_if.alu b  // Operands in, results out
);
  logic [8:0] sum;  // Full negation with carry out
  logic [4:0] lo;   // Low nibble negation with carry out

  // Two's complement as inverse plus one; C and HC from the carries, Z and N from the result, SW from operand and result signs
  always_comb begin
    sum = {1'b0, ~b.opnd} + 9'h001;
    lo  = {1'b0, ~b.opnd[3:0]} + 5'h01;
    b.neg_res              = sum[7:0];
    b.neg_flags            = '0;
    b.neg_flags[`MIS_ST_C]  = sum[8];
    b.neg_flags[`MIS_ST_HC] = lo[4];
    b.neg_flags[`MIS_ST_Z]  = (sum[7:0] == 8'h00);
    b.neg_flags[`MIS_ST_SW] = b.opnd[7] & sum[7];
    b.neg_flags[`MIS_ST_N]  = sum[7];
    // Unsigned product of accumulator and literal or data byte
    b.prod = {8'h00, b.acc} * {8'h00, (b.use_lit ? b.lit : b.opnd)};
  end
endmodule : mis_alu

`default_nettype wire

//--- verilog/mis_exec.sv
// Instruction subset executor with Avalon-MM register access
`timescale 1ns/10ps
`default_nettype none
`include "mis_cfg.svh"

module mis_exec #(
  parameter int STACK_DEPTH = 31,  // Return stack entries
  parameter int PC_W        = 21   // Program counter width
) (
  input  wire logic        mclk,                         // Core clock
  input  wire logic        rst,                          // Async reset, high
  input  wire logic [7:0]  avs_address,                  // Byte address
  input  wire logic        avs_read,                     // Read request
  input  wire logic        avs_write,                    // Write request
  input  wire logic [31:0] avs_writedata,                // Write data
  input  wire logic [3:0]  avs_byteenable,               // Byte lanes
  output logic      [31:0] avs_readdata,                 // Read data
  output logic             avs_waitrequest,              // Stall
  output logic             busy,                         // Instruction running
  output logic             high_priority_global_enable,  // High enable
  output logic             low_priority_global_enable    // Low enable
);
  localparam int SP_W = $clog2(STACK_DEPTH + 1);

  // Architectural state
  mis_pkg::mis_phase_t phase_r, phase_nxt;                 // Quarter sequencer
  mis_pkg::mis_op_t    op_r, op_nxt;                       // Decoded operation
  logic [15:0]     instr_r, instr_nxt;                     // Instruction word
  logic [7:0]      acc_r, acc_nxt;                         // Accumulator
  logic [4:0]      status_r, status_nxt;                   // Flags
  logic [3:0]      bank_sel_r, bank_sel_nxt;               // Bank select
  logic [7:0]      prod_lo_r, prod_lo_nxt;                 // Product low
  logic [7:0]      prod_hi_r, prod_hi_nxt;                 // Product high
  logic [PC_W-1:0] pc_r, pc_nxt;                           // Program counter
  logic [SP_W-1:0] sp_r, sp_nxt;                           // Stack fill level
  logic            gen_hi_r, gen_hi_nxt;                   // High enable
  logic            gen_lo_r, gen_lo_nxt;                   // Low enable
  logic [7:0]      acc_shadow_r, acc_shadow_nxt;           // Accumulator copy
  logic [4:0]      flags_shadow_r, flags_shadow_nxt;       // Status copy
  logic [3:0]      bank_shadow_r, bank_shadow_nxt;         // Bank copy
  logic [7:0]      pc_latch_high_r, pc_latch_high_nxt;     // PC latch high
  logic [4:0]      pc_latch_upper_r, pc_latch_upper_nxt;   // PC latch upper
  logic [7:0]      opnd_r, opnd_nxt;                       // Operand read in Q2
  logic [7:0]      res_r, res_nxt;                         // Result of Q3
  logic [4:0]      rflags_r, rflags_nxt;                   // Flags of Q3
  logic [15:0]     prod_r, prod_nxt;                       // Product of Q3
  logic [11:0]     dm_addr_r, dm_addr_nxt;                 // Debug memory pointer
  logic            wait_r, wait_nxt;                       // Waitrequest
  logic [31:0]     rdata_r, rdata_nxt;                     // Read data
  logic            busy_r, busy_nxt;                       // Busy flag

  // Memories
  logic [7:0]      dmem [0:4095];                          // Data memory
  logic [PC_W-1:0] stack [0:STACK_DEPTH-1];                // Return stack

  // Memory write strobes
  logic            dm_we;                                  // Data write enable
  logic [11:0]     dm_wa;                                  // Data write address
  logic [7:0]      dm_wd;                                  // Data write value
  logic            stk_we;                                 // Stack write enable
  logic [SP_W-1:0] stk_wa;                                 // Stack write slot
  logic [PC_W-1:0] stk_wd;                                 // Stack write value

  // Helpers
  logic [PC_W-1:0] stack_top;                              // Current top entry
  logic [PC_W-1:0] pc_ret;                                 // PC plus two
  logic [PC_W-1:0] rel_off;                                // Twice the offset
  logic [11:0]     fa;                                     // Operand address
  logic [31:0]     rd_mux;                                 // Register at address
  logic [31:0]     mw;                                     // Merged write value
  logic            req;                                    // Request accepted
  logic            wr_go;                                  // Write commits

  mis_alu_if alu_bus ();                                   // Arithmetic carrier

  // Decode an instruction word to an operation
  function automatic mis_pkg::mis_op_t op_decode(input logic [15:0] iw);
    mis_pkg::mis_op_t op;
    op = mis_pkg::OP_NOP;
    if (iw == `MIS_OPC_POP) op = mis_pkg::OP_POP;
    else if (iw == `MIS_OPC_PUSH) op = mis_pkg::OP_PUSH;
    else if (iw == `MIS_OPC_RESET) op = mis_pkg::OP_RESET;
    else if (iw[15:1] == `MIS_OPC_IRET) op = mis_pkg::OP_IRET;
    else if (iw[15:8] == `MIS_OPC_RET_LIT) op = mis_pkg::OP_RET_LIT;
    else if (iw[15:8] == `MIS_OPC_MUL_LIT) op = mis_pkg::OP_MUL_LIT;
    else if (iw[15:9] == `MIS_OPC_MUL_REG) op = mis_pkg::OP_MUL_REG;
    else if (iw[15:9] == `MIS_OPC_NEGATE) op = mis_pkg::OP_NEGATE;
    else if (iw[15:11] == `MIS_OPC_REL_CALL) op = mis_pkg::OP_REL_CALL;
    return op;
  endfunction : op_decode

  // Operand address: bank bit clear picks the access bank halves
  function automatic logic [11:0] file_addr(input logic [15:0] iw, input logic [3:0] bank);
    logic [3:0] b;
    b = iw[8] ? bank : (iw[7] ? `MIS_ACC_HI_BANK : `MIS_ACC_LO_BANK);
    return {b, iw[7:0]};
  endfunction : file_addr

  // Merge write data into a register image lane by lane
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) m[i*8 +: 8] = wd[i*8 +: 8];
    end
    return m;
  endfunction : be_merge

  mis_alu u_alu (
    .b (alu_bus)
  );

  // Arithmetic operands
  assign alu_bus.acc     = acc_r;
  assign alu_bus.opnd    = opnd_r;
  assign alu_bus.lit     = instr_r[7:0];
  assign alu_bus.use_lit = (op_r == mis_pkg::OP_MUL_LIT);

  // Stack and address helpers
  assign stack_top = (sp_r == '0) ? '0 : stack[sp_r - SP_W'(1)];
  assign pc_ret    = pc_r + PC_W'(`MIS_PC_STEP);
  assign rel_off   = {{(PC_W-12){instr_r[10]}}, instr_r[10:0], 1'b0};
  assign fa        = file_addr(instr_r, bank_sel_r);

  // Register image at the bus address; unmapped reads zero
  always_comb begin
    unique case (avs_address)
      `MIS_OFF_CTRL:     rd_mux = {12'h000, phase_r, instr_r};
      `MIS_OFF_ACC:      rd_mux = 32'(acc_r);
      `MIS_OFF_STATUS:   rd_mux = 32'(status_r);
      `MIS_OFF_BANK_SEL: rd_mux = 32'(bank_sel_r);
      `MIS_OFF_PROD_LO:  rd_mux = 32'(prod_lo_r);
      `MIS_OFF_PROD_HI:  rd_mux = 32'(prod_hi_r);
      `MIS_OFF_PC:       rd_mux = 32'(pc_r);
      `MIS_OFF_STK_TOP:  rd_mux = 32'(stack_top);
      `MIS_OFF_STK_PTR:  rd_mux = 32'(sp_r);
      `MIS_OFF_IRQ_EN:   rd_mux = 32'({gen_hi_r, gen_lo_r});
      `MIS_OFF_SHADOW:   rd_mux = 32'({bank_shadow_r, flags_shadow_r, acc_shadow_r});
      `MIS_OFF_PC_LATCH: rd_mux = 32'({pc_latch_upper_r, pc_latch_high_r});
      `MIS_OFF_DM_ADDR:  rd_mux = 32'(dm_addr_r);
      `MIS_OFF_DM_DATA:  rd_mux = 32'(dmem[dm_addr_r]);
      default:           rd_mux = '0;
    endcase
  end

  // Next state: bus slave and quarter sequencer
  always_comb begin
    phase_nxt = phase_r;   op_nxt = op_r;           instr_nxt = instr_r;
    acc_nxt = acc_r;       status_nxt = status_r;   bank_sel_nxt = bank_sel_r;
    prod_lo_nxt = prod_lo_r;  prod_hi_nxt = prod_hi_r;
    pc_nxt = pc_r;         sp_nxt = sp_r;
    gen_hi_nxt = gen_hi_r; gen_lo_nxt = gen_lo_r;
    acc_shadow_nxt = acc_shadow_r;  flags_shadow_nxt = flags_shadow_r;
    bank_shadow_nxt = bank_shadow_r;
    pc_latch_high_nxt = pc_latch_high_r;  pc_latch_upper_nxt = pc_latch_upper_r;
    opnd_nxt = opnd_r;     res_nxt = res_r;  rflags_nxt = rflags_r;  prod_nxt = prod_r;
    dm_addr_nxt = dm_addr_r;
    rdata_nxt = rdata_r;
    dm_we = 1'b0;  dm_wa = fa;  dm_wd = res_r;
    stk_we = 1'b0; stk_wa = sp_r; stk_wd = pc_ret;
    mw = be_merge(rd_mux, avs_writedata, avs_byteenable);
    // Answer one cycle after a request, only while no instruction runs
    req      = (avs_read || avs_write) && wait_r && (phase_r == mis_pkg::PH_IDLE);
    wr_go    = avs_write && !wait_r;
    wait_nxt = !req;
    if (req) rdata_nxt = avs_read ? rd_mux : '0;
    // Register writes land at the edge that sees waitrequest low
    if (wr_go) begin
      unique case (avs_address)
        `MIS_OFF_CTRL: begin
          instr_nxt = mw[15:0];
          phase_nxt = mis_pkg::PH_Q1;
        end
        `MIS_OFF_ACC:      acc_nxt = mw[7:0];
        `MIS_OFF_STATUS:   status_nxt = mw[4:0];
        `MIS_OFF_BANK_SEL: bank_sel_nxt = mw[3:0];
        `MIS_OFF_PROD_LO:  prod_lo_nxt = mw[7:0];
        `MIS_OFF_PROD_HI:  prod_hi_nxt = mw[7:0];
        `MIS_OFF_PC:       pc_nxt = mw[PC_W-1:0];
        `MIS_OFF_STK_TOP: begin
          stk_we = (sp_r != '0);
          stk_wa = sp_r - SP_W'(1);
          stk_wd = mw[PC_W-1:0];
        end
        `MIS_OFF_STK_PTR:  sp_nxt = (mw[SP_W-1:0] > SP_W'(STACK_DEPTH)) ? sp_r : mw[SP_W-1:0];
        `MIS_OFF_IRQ_EN: begin
          gen_hi_nxt = mw[1];
          gen_lo_nxt = mw[0];
        end
        `MIS_OFF_SHADOW: begin
          acc_shadow_nxt   = mw[7:0];
          flags_shadow_nxt = mw[12:8];
          bank_shadow_nxt  = mw[16:13];
        end
        `MIS_OFF_PC_LATCH: begin
          pc_latch_high_nxt  = mw[7:0];
          pc_latch_upper_nxt = mw[12:8];
        end
        `MIS_OFF_DM_ADDR:  dm_addr_nxt = mw[11:0];
        `MIS_OFF_DM_DATA: begin
          dm_we = 1'b1;
          dm_wa = dm_addr_r;
          dm_wd = mw[7:0];
        end
        default: ;
      endcase
    end
    // Quarter sequencer
    unique case (phase_r)
      mis_pkg::PH_IDLE: ;
      mis_pkg::PH_Q1: begin
        op_nxt    = op_decode(instr_r);
        phase_nxt = mis_pkg::PH_Q2;
      end
      mis_pkg::PH_Q2: begin
        phase_nxt = mis_pkg::PH_Q3;
        if (op_r == mis_pkg::OP_NEGATE || op_r == mis_pkg::OP_MUL_REG)
          opnd_nxt = dmem[fa];
        if (op_r == mis_pkg::OP_PUSH || op_r == mis_pkg::OP_REL_CALL) begin
          // Return address goes on the stack before the PC moves
          stk_we = (sp_r < SP_W'(STACK_DEPTH));
          if (stk_we) sp_nxt = sp_r + SP_W'(1);
        end
        if (op_r == mis_pkg::OP_RESET) begin
          acc_nxt = '0;  status_nxt = '0;  bank_sel_nxt = '0;
          prod_lo_nxt = '0;  prod_hi_nxt = '0;  pc_nxt = '0;  sp_nxt = '0;
          gen_hi_nxt = 1'b0;  gen_lo_nxt = 1'b0;
          acc_shadow_nxt = '0;  flags_shadow_nxt = '0;  bank_shadow_nxt = '0;
          pc_latch_high_nxt = '0;  pc_latch_upper_nxt = '0;
        end
      end
      mis_pkg::PH_Q3: begin
        phase_nxt  = mis_pkg::PH_Q4;
        res_nxt    = alu_bus.neg_res;
        rflags_nxt = alu_bus.neg_flags;
        prod_nxt   = alu_bus.prod;
        if (op_r == mis_pkg::OP_POP && sp_r != '0)
          sp_nxt = sp_r - SP_W'(1);
      end
      mis_pkg::PH_Q4: begin
        phase_nxt = mis_pkg::PH_IDLE;
        pc_nxt    = pc_ret;
        unique case (op_r)
          mis_pkg::OP_NEGATE: begin
            dm_we      = 1'b1;
            status_nxt = rflags_r;
          end
          mis_pkg::OP_MUL_REG, mis_pkg::OP_MUL_LIT: begin
            prod_lo_nxt = prod_r[7:0];
            prod_hi_nxt = prod_r[15:8];
          end
          mis_pkg::OP_REL_CALL: begin
            pc_nxt    = pc_ret + rel_off;
            phase_nxt = mis_pkg::PH_N1;
          end
          mis_pkg::OP_RESET: pc_nxt = pc_r;
          mis_pkg::OP_IRET, mis_pkg::OP_RET_LIT: begin
            // Pop into PC; the PC latch registers are not touched
            pc_nxt    = stack_top;
            sp_nxt    = (sp_r != '0) ? sp_r - SP_W'(1) : sp_r;
            phase_nxt = mis_pkg::PH_N1;
            if (op_r == mis_pkg::OP_RET_LIT) acc_nxt = instr_r[7:0];
            if (op_r == mis_pkg::OP_IRET) begin
              // Re-enable high level first, else the low level
              if (!gen_hi_r) gen_hi_nxt = 1'b1;
              else gen_lo_nxt = 1'b1;
              if (instr_r[0]) begin
                acc_nxt      = acc_shadow_r;
                status_nxt   = flags_shadow_r;
                bank_sel_nxt = bank_shadow_r;
              end
            end
          end
          default: ;
        endcase
      end
      // Second cycle of two-cycle operations does nothing
      mis_pkg::PH_N1: phase_nxt = mis_pkg::PH_N2;
      mis_pkg::PH_N2: phase_nxt = mis_pkg::PH_N3;
      mis_pkg::PH_N3: phase_nxt = mis_pkg::PH_N4;
      mis_pkg::PH_N4: phase_nxt = mis_pkg::PH_IDLE;
      default:        phase_nxt = mis_pkg::PH_IDLE;
    endcase
    busy_nxt = (phase_nxt != mis_pkg::PH_IDLE);
  end

  // State registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_r <= mis_pkg::PH_IDLE;  op_r <= mis_pkg::OP_NOP;  instr_r <= '0;
      acc_r <= '0;  status_r <= '0;  bank_sel_r <= '0;
      prod_lo_r <= '0;  prod_hi_r <= '0;  pc_r <= '0;  sp_r <= '0;
      gen_hi_r <= 1'b0;  gen_lo_r <= 1'b0;
      acc_shadow_r <= '0;  flags_shadow_r <= '0;  bank_shadow_r <= '0;
      pc_latch_high_r <= '0;  pc_latch_upper_r <= '0;
      opnd_r <= '0;  res_r <= '0;  rflags_r <= '0;  prod_r <= '0;
      dm_addr_r <= '0;  wait_r <= 1'b1;  rdata_r <= '0;  busy_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;  op_r <= op_nxt;  instr_r <= instr_nxt;
      acc_r <= acc_nxt;  status_r <= status_nxt;  bank_sel_r <= bank_sel_nxt;
      prod_lo_r <= prod_lo_nxt;  prod_hi_r <= prod_hi_nxt;  pc_r <= pc_nxt;  sp_r <= sp_nxt;
      gen_hi_r <= gen_hi_nxt;  gen_lo_r <= gen_lo_nxt;
      acc_shadow_r <= acc_shadow_nxt;  flags_shadow_r <= flags_shadow_nxt;
      bank_shadow_r <= bank_shadow_nxt;
      pc_latch_high_r <= pc_latch_high_nxt;  pc_latch_upper_r <= pc_latch_upper_nxt;
      opnd_r <= opnd_nxt;  res_r <= res_nxt;  rflags_r <= rflags_nxt;  prod_r <= prod_nxt;
      dm_addr_r <= dm_addr_nxt;  wait_r <= wait_nxt;  rdata_r <= rdata_nxt;
      busy_r <= busy_nxt;
    end
  end

  // Memory writes, no reset
  always_ff @(posedge mclk) begin
    if (dm_we) dmem[dm_wa] <= dm_wd;
    if (stk_we) stack[stk_wa] <= stk_wd;
  end

  // Outputs from flip-flops
  assign avs_readdata                = rdata_r;
  assign avs_waitrequest             = wait_r;
  assign busy                        = busy_r;
  assign high_priority_global_enable = gen_hi_r;
  assign low_priority_global_enable  = gen_lo_r;

endmodule : mis_exec

`default_nettype wire

//--- sim/mis_exec_props.sv
// Port-level assertions for the instruction subset executor
`timescale 1ns/10ps
`default_nettype none
module mis_exec_props (
  input wire logic mclk,                         // Core clock
  input wire logic rst,                          // Async reset, high
  input wire logic avs_read,                     // Read request
  input wire logic avs_write,                    // Write request
  input wire logic avs_waitrequest,              // Stall
  input wire logic busy,                         // Instruction running
  input wire logic high_priority_global_enable,  // High enable
  input wire logic low_priority_global_enable    // Low enable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Short aliases for the two enables
  wire logic hi = high_priority_global_enable;
  wire logic lo = low_priority_global_enable;
  property p_ack_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_ack_one: assert property (p_ack_one) else $error("waitrequest low twice");
  property p_ack_cause; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
  property p_start; $rose(busy) |-> $past(avs_write && !avs_waitrequest); endproperty
  a_start: assert property (p_start) else $error("busy without a write");
  property p_len; $rose(busy) |-> busy[*4] ##1 (!busy or (busy[*4] ##1 !busy)); endproperty
  a_len: assert property (p_len) else $error("busy not four or eight cycles");
  property p_stall; busy |-> avs_waitrequest; endproperty
  a_stall: assert property (p_stall) else $error("answer while running");
  property p_en_rise;
    ($rose(hi) || $rose(lo)) |-> busy || $past(avs_write && !avs_waitrequest);
  endproperty
  a_en_rise: assert property (p_en_rise) else $error("enable set outside an instruction");
  property p_en_one; ($rose(hi) && $rose(lo)) |-> !$past(busy); endproperty
  a_en_one: assert property (p_en_one) else $error("both enables set at once");
  property p_en_fall;
    ($fell(hi) || $fell(lo)) |-> $past(busy) || $past(avs_write && !avs_waitrequest);
  endproperty
  a_en_fall: assert property (p_en_fall) else $error("enable cleared without cause");
endmodule : mis_exec_props
bind mis_exec mis_exec_props u_props (.mclk, .rst, .avs_read, .avs_write, .avs_waitrequest,
  .busy, .high_priority_global_enable, .low_priority_global_enable);
`default_nettype wire

//--- sim/mis_exec_tb.sv
// Self-checking bench for the instruction subset executor
`timescale 1ns/10ps
`default_nettype none
module mis_exec_tb;
  logic        mclk = 1'b0;                     // Core clock
  logic        rst, avs_read, avs_write;        // Reset and requests
  logic [7:0]  avs_address, seed, a, x, f, b, k; // Address and random draws
  logic [31:0] avs_writedata, avs_readdata, rdat, sh; // Bus data, last read, shadows
  logic [3:0]  avs_byteenable;                  // Byte lanes
  logic        avs_waitrequest, busy, hi, lo;   // Design status
  logic [20:0] pc;                              // Program counter model
  logic [15:0] p;                               // Expected product
  int          n_fail, n_compared, nb;          // Counters
  always #2.5 mclk = ~mclk;
  mis_exec dut (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .busy(busy),
    .high_priority_global_enable(hi), .low_priority_global_enable(lo));
  // Shift register source of random bytes
  function automatic logic [7:0] rnd();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction : rnd
  // Expected flags after negation: N, sign wrap, Z, half carry, C
  function automatic logic [31:0] nflags(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00 - v;
    return {27'h0, r[7], v == 8'h80, r == 8'h00, v[3:0] == 4'h0, v == 8'h00};
  endfunction : nflags
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic rw, input logic [7:0] ad, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= ad;
    avs_writedata <= d;
    avs_read <= !rw;
    avs_write <= rw;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rc(input string nm, input logic [7:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h0);
    chk(nm, e, rdat);
  endtask : rc
  // Run one instruction and count its busy cycles
  task automatic ex(input logic [15:0] w, input int cy);
    bus(1'b1, 8'h00, {16'h0, w});
    nb = 0;
    @(posedge mclk);
    while (busy === 1'b1) begin
      nb++;
      @(posedge mclk);
    end
    chk("busy cycles", cy, nb);
  endtask : ex
  task automatic end_sim();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  // Hang guard, far beyond the expected run
  initial begin
    #100us;
    n_fail++;
    end_sim();
  end
  initial begin
    {rst, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 42'h0};
    avs_byteenable = 4'hF;
    {seed, n_fail, n_compared} = {8'h52, 64'h0};
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    // Reset values from 0x04 to 0x2C, stack top excepted, and an unmapped place
    for (int i = 1; i < 12; i++) if (i != 7) rc("reset value", 8'(i * 4), 32'h0);
    rc("unmapped", 8'hFC, 32'h0);
    // Data byte operations with a decoy in the other bank
    for (int i = 0; i < 6; i++) begin
      x = (i == 0) ? 8'h3A : (i == 1) ? 8'h00 : (i == 2) ? 8'h80 : rnd();
      a = (i == 0) ? 8'hE2 : rnd();
      k = (i == 0) ? 8'hC4 : rnd();
      f = rnd();
      b = rnd();
      bus(1'b1, 8'h0C, {28'h0, b[3:0]});
      bus(1'b1, 8'h04, {24'h0, a});
      bus(1'b1, 8'h30, {20'h0, i[0] ? {f[7] ? 4'hF : 4'h0, f} : {b[3:0], f}});
      bus(1'b1, 8'h34, {24'h0, ~x});
      bus(1'b1, 8'h30, {20'h0, i[0] ? {b[3:0], f} : {f[7] ? 4'hF : 4'h0, f}});
      bus(1'b1, 8'h34, {24'h0, x});
      p = a * x;
      ex({7'h01, i[0], f}, 4);
      rc("reg prod lo", 8'h10, {24'h0, p[7:0]});
      rc("reg prod hi", 8'h14, {24'h0, p[15:8]});
      ex({7'h36, i[0], f}, 4);
      rc("negated", 8'h34, {24'h0, 8'h00 - x});
      rc("neg flags", 8'h08, nflags(x));
      p = a * k;
      ex({8'h0D, k}, 4);
      rc("lit prod lo", 8'h10, {24'h0, p[7:0]});
      rc("lit prod hi", 8'h14, {24'h0, p[15:8]});
      rc("flags kept", 8'h08, nflags(x));
      rc("acc kept", 8'h04, {24'h0, a});
    end
    // Stack, calls and returns
    pc = {11'h0, rnd(), 2'b00} + 21'h0_1000;
    bus(1'b1, 8'h18, {11'h0, pc});
    bus(1'b1, 8'h2C, 32'h0000_1ABC);
    ex(16'h0005, 4);
    ex(16'h0005, 4);
    rc("push top", 8'h1C, {11'h0, pc + 21'd4});
    rc("push fill", 8'h20, 32'h2);
    ex(16'h0006, 4);
    rc("pop top", 8'h1C, {11'h0, pc + 21'd2});
    ex(16'hDC00, 8);
    rc("call back", 8'h18, {11'h0, pc + 21'd8 - 21'd2048});
    rc("call ret", 8'h1C, {11'h0, pc + 21'd8});
    k = rnd();
    ex({8'h0C, k}, 8);
    rc("lit acc", 8'h04, {24'h0, k});
    rc("lit pc", 8'h18, {11'h0, pc + 21'd8});
    ex(16'hDBFF, 8);
    rc("call fwd", 8'h18, {11'h0, pc + 21'd10 + 21'd2046});
    sh = {rnd(), rnd(), rnd(), rnd()} & 32'h0001_FFFF;
    bus(1'b1, 8'h28, sh);
    ex(16'h0011, 8);
    rc("iret pc", 8'h18, {11'h0, pc + 21'd10});
    rc("shadow acc", 8'h04, {24'h0, sh[7:0]});
    rc("shadow flags", 8'h08, {27'h0, sh[12:8]});
    rc("shadow bank", 8'h0C, {28'h0, sh[16:13]});
    chk("high enable", 32'h1, {31'h0, hi});
    bus(1'b1, 8'h04, {24'h0, k});
    ex(16'h0010, 8);
    rc("iret pc", 8'h18, {11'h0, pc + 21'd2});
    rc("acc untouched", 8'h04, {24'h0, k});
    rc("enables", 8'h24, 32'h3);
    chk("low enable", 32'h1, {31'h0, lo});
    rc("latch kept", 8'h2C, 32'h0000_1ABC);
    // Lane zero disabled: the accumulator must keep its value
    avs_byteenable <= 4'hE;
    bus(1'b1, 8'h04, {24'h0, ~k});
    avs_byteenable <= 4'hF;
    rc("lane kept", 8'h04, {24'h0, k});
    ex({4'hF, rnd(), 4'h5}, 4);
    ex(16'h0000, 4);
    rc("nop pc", 8'h18, {11'h0, pc + 21'd6});
    rc("nop acc", 8'h04, {24'h0, k});
    // Enables written by software show on the pins a cycle later
    bus(1'b1, 8'h24, 32'h1);
    @(posedge mclk);
    chk("high port", 32'h0, {31'h0, hi});
    chk("low port", 32'h1, {31'h0, lo});
    ex(16'h00FF, 4);
    for (int i = 1; i < 12; i++) if (i != 7) rc("soft reset", 8'(i * 4), 32'h0);
    end_sim();
  end
endmodule : mis_exec_tb
`default_nettype wire
